// ==== rtl/comp_pkg.sv ====
/*
 * Shared constants for the dual comparator control block: register map,
 * field positions, reset values and input channel codes.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package comp_pkg;
	// Sizes
	localparam int NUM_COMP = 2;
	localparam int ADDR_W = 5;
	localparam int PORT_W = 8;
	localparam int NEG_PINS = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL0_BASE = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL1_BASE = 5'h04;
	localparam logic [ADDR_W-1:0] CTRL_STRIDE = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_SHARED_RESULT = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 5'h18;

	// comp_control_reg0 fields
	localparam int CTL0_ENABLE = 7;
	localparam int CTL0_RESULT = 6;
	localparam int CTL0_INVERT = 4;
	localparam int CTL0_SPEED = 2;
	localparam int CTL0_HYST = 1;
	localparam int CTL0_SYNC = 0;

	// comp_control_reg1 fields
	localparam int CTL1_RISE = 7;
	localparam int CTL1_FALL = 6;
	localparam int CTL1_PCH_LSB = 3;
	localparam int CTL1_NCH_LSB = 0;

	// Reset values
	localparam logic [7:0] CTRL0_RESET = 8'h04;
	localparam logic [7:0] CTRL1_RESET = 8'h00;

	// Channel select codes
	localparam logic [2:0] POS_PIN = 3'h0;
	localparam logic [2:0] POS_DAC = 3'h5;
	localparam logic [2:0] POS_FVR = 3'h6;
	localparam logic [2:0] POS_GND = 3'h7;
	localparam logic [2:0] NEG_FVR = 3'h6;
	localparam logic [2:0] NEG_GND = 3'h7;
	localparam logic [2:0] NEG_PIN_LAST = 3'h3;

	// Bus slave states
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;
endpackage : comp_pkg

// ==== rtl/sync3.sv ====
/*
 * Three-stage synchroniser for one asynchronous level.
 * Assumes the input may change at any time relative to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;
	logic stage2;
	logic stage3;

	// Chain; output moves only once stages two and three agree
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				sync_out <= stage3;
		end
	end
endmodule : sync3
`default_nettype wire

// ==== rtl/comp_input_mux.sv ====
/*
 * Input channel decoder for one comparator: turns the channel fields into
 * registered analog switch enables.
 * Assumes the analog core closes a switch while its enable is high.
 */
`timescale 1ns/1ps
`default_nettype none
module comp_input_mux
	import comp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Settings
	input wire logic comp_enable,
	input wire logic [2:0] positive_channel_sel,
	input wire logic [2:0] negative_channel_sel,
	// Positive switches
	output logic pos_pin,
	output logic pos_dac,
	output logic pos_fvr,
	output logic pos_gnd,
	// Negative switches
	output logic [comp_pkg::NEG_PINS-1:0] neg_pin,
	output logic neg_fvr,
	output logic neg_gnd
);
	import comp_pkg::*;

	// Decode codes; all switches open while disabled
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pos_pin <= 1'b0;
			pos_dac <= 1'b0;
			pos_fvr <= 1'b0;
			pos_gnd <= 1'b0;
			neg_pin <= '0;
			neg_fvr <= 1'b0;
			neg_gnd <= 1'b0;
		end
		else
		begin
			pos_pin <= comp_enable && positive_channel_sel == POS_PIN;
			pos_dac <= comp_enable && positive_channel_sel == POS_DAC;
			pos_fvr <= comp_enable && positive_channel_sel == POS_FVR;
			pos_gnd <= comp_enable && positive_channel_sel == POS_GND;
			for (int k = 0; k < NEG_PINS; k++)
				neg_pin[k] <= comp_enable && negative_channel_sel == 3'(k);
			neg_fvr <= comp_enable && negative_channel_sel == NEG_FVR;
			neg_gnd <= comp_enable && negative_channel_sel == NEG_GND;
		end
	end
endmodule : comp_input_mux
`default_nettype wire

// ==== rtl/dual_comparator_control.sv ====
/*
 * Digital control for two analog comparators: registers, output polarity,
 * instruction-cycle latch, timer-synchronised copy, edge interrupt flags,
 * wake request, waveform shutdown and analog-aware port read.
 * Assumes an Avalon-MM master on clk, asynchronous comparator results,
 * and a gate timer source clock that is slow against clk.
 */
// Register access over Avalon-MM and the placing of the registers were decided locally.
// Behaviour
// - raw result high when positive input exceeds negative input
// - enable bit runs comparator; clear powers it down
// - result readable in own control register and shared mirror register
// - internal output latched every instruction cycle
// - external output copies are unlatched unless sync mode chosen
// - polarity bit 0 passes result, 1 inverts it
// - inverting equals swapping the two inputs
// - hysteresis bit switches the input hysteresis on or off
// - each output offered as gate source to the gate timer
// - sync bit latches output on timer clock falling edge
// - enabled rising or falling output edge sets the interrupt flag
// - only software clears flag; a coinciding edge keeps it set
// - edges seen on polarity-adjusted output, even while disabled
// - positive field picks pin, converter, reference or ground
// - all inputs disconnected while comparator disabled
// - negative field picks a pin, reference or ground
// - active output with shutdown enable suspends waveform generator at once
// - sync outputs stop in sleep when timer runs from core clock
// - enabled comparator interrupt wakes device from sleep
// - pins set analog read back as zero
// - positive codes 111 ground, 110 reference, 101 converter, 000 pin
// - negative codes 111 ground, 110 reference, 011..000 pins
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control
	import comp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [comp_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Analog comparator cores
	input wire logic [comp_pkg::NUM_COMP-1:0] raw_result,
	output logic [comp_pkg::NUM_COMP-1:0] core_power_en,
	output logic [comp_pkg::NUM_COMP-1:0] core_speed_sel,
	output logic [comp_pkg::NUM_COMP-1:0] core_hysteresis_en,
	// Input switches per comparator
	output logic [comp_pkg::NUM_COMP-1:0] pos_pin_sw,
	output logic [comp_pkg::NUM_COMP-1:0] pos_dac_sw,
	output logic [comp_pkg::NUM_COMP-1:0] pos_fvr_sw,
	output logic [comp_pkg::NUM_COMP-1:0] pos_gnd_sw,
	output logic [comp_pkg::NUM_COMP*comp_pkg::NEG_PINS-1:0] neg_pin_sw,
	output logic [comp_pkg::NUM_COMP-1:0] neg_fvr_sw,
	output logic [comp_pkg::NUM_COMP-1:0] neg_gnd_sw,
	// Gate timer
	input wire logic timer_src_clk,
	input wire logic timer_src_is_core_clock,
	input wire logic sleep_mode,
	output logic [comp_pkg::NUM_COMP-1:0] gate_timer_src,
	// Waveform generator and pins
	input wire logic [comp_pkg::NUM_COMP-1:0] shutdown_source_enable,
	output logic waveform_shutdown,
	output logic [comp_pkg::NUM_COMP-1:0] pin_output,
	// Interrupt and wake
	output logic [comp_pkg::NUM_COMP-1:0] comp_irq_request,
	output logic wake_request,
	// Digital port read
	input wire logic [comp_pkg::PORT_W-1:0] pin_level,
	input wire logic [comp_pkg::PORT_W-1:0] analog_pin_select,
	output logic [comp_pkg::PORT_W-1:0] port_read_value
);
	import comp_pkg::*;

	// Bus slave state
	bus_state_t bus_state;
	logic access;
	logic wr_now;
	logic [7:0] wr_byte;

	// Software settings
	logic [NUM_COMP-1:0] comp_enable;
	logic [NUM_COMP-1:0] output_invert;
	logic [NUM_COMP-1:0] speed_sel;
	logic [NUM_COMP-1:0] hysteresis_enable;
	logic [NUM_COMP-1:0] timer_sync_enable;
	logic [NUM_COMP-1:0] rising_edge_irq_enable;
	logic [NUM_COMP-1:0] falling_edge_irq_enable;
	logic [2:0] positive_channel_sel [NUM_COMP];
	logic [2:0] negative_channel_sel [NUM_COMP];
	logic [NUM_COMP-1:0] comp_irq_enable;
	logic [NUM_COMP-1:0] comp_irq_flag;

	// Datapath
	logic [NUM_COMP-1:0] raw_sync;
	logic [NUM_COMP-1:0] comp_result_bit;
	logic [NUM_COMP-1:0] prev_result;
	logic [NUM_COMP-1:0] edge_hit;
	logic [NUM_COMP-1:0] flag_clear;
	logic [NUM_COMP-1:0] async_copy;
	logic [NUM_COMP-1:0] sync_copy;
	logic [NUM_COMP-1:0] ext_copy;
	logic tclk_sync;
	logic tclk_prev;
	logic tclk_fall;
	logic sync_halt;
	logic [PORT_W-1:0] pin_sync;

	// Request accepted in the answer cycle only
	assign access = read || write;
	assign waitrequest = access && bus_state == BUS_IDLE;
	assign wr_now = write && bus_state == BUS_ANSWER && byteenable[0];
	assign wr_byte = writedata[7:0];

	// One wait cycle per access, then answer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			bus_state <= BUS_IDLE;
		else
		begin
			case (bus_state)
				BUS_IDLE:
					if (access)
						bus_state <= BUS_ANSWER;
				BUS_ANSWER:
					bus_state <= BUS_IDLE;
				default:
					bus_state <= BUS_IDLE;
			endcase
		end
	end

	// Read data prepared during the wait cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			readdata <= '0;
		else if (read && bus_state == BUS_IDLE)
		begin
			readdata <= '0;
			for (int i = 0; i < NUM_COMP; i++)
			begin
				if (address == ADDR_W'(OFF_CTRL0_BASE + i * CTRL_STRIDE))
				begin
					readdata[CTL0_ENABLE] <= comp_enable[i];
					readdata[CTL0_RESULT] <= comp_result_bit[i];
					readdata[CTL0_INVERT] <= output_invert[i];
					readdata[CTL0_SPEED] <= speed_sel[i];
					readdata[CTL0_HYST] <= hysteresis_enable[i];
					readdata[CTL0_SYNC] <= timer_sync_enable[i];
				end
				if (address == ADDR_W'(OFF_CTRL1_BASE + i * CTRL_STRIDE))
				begin
					readdata[CTL1_RISE] <= rising_edge_irq_enable[i];
					readdata[CTL1_FALL] <= falling_edge_irq_enable[i];
					readdata[CTL1_PCH_LSB +: 3] <= positive_channel_sel[i];
					readdata[CTL1_NCH_LSB +: 3] <= negative_channel_sel[i];
				end
			end
			if (address == OFF_SHARED_RESULT)
				readdata[NUM_COMP-1:0] <= comp_result_bit;
			if (address == OFF_IRQ_FLAG)
				readdata[NUM_COMP-1:0] <= comp_irq_flag;
			if (address == OFF_IRQ_ENABLE)
				readdata[NUM_COMP-1:0] <= comp_irq_enable;
		end
	end

	// Interrupt enable register
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			comp_irq_enable <= '0;
		else if (wr_now && address == OFF_IRQ_ENABLE)
			comp_irq_enable <= wr_byte[NUM_COMP-1:0];
	end

	// Timer source clock edge and sleep stop
	sync3 u_tclk_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in(timer_src_clk),
		.sync_out(tclk_sync)
	);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tclk_prev <= 1'b0;
		else
			tclk_prev <= tclk_sync;
	end

	assign tclk_fall = tclk_prev && !tclk_sync;
	assign sync_halt = sleep_mode && timer_src_is_core_clock;

	// Per comparator logic
	generate
		for (genvar i = 0; i < NUM_COMP; i++)
		begin : g_comp
			localparam logic [ADDR_W-1:0] A0 = ADDR_W'(OFF_CTRL0_BASE + i * CTRL_STRIDE);
			localparam logic [ADDR_W-1:0] A1 = ADDR_W'(OFF_CTRL1_BASE + i * CTRL_STRIDE);

			// Control register 0 fields
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					comp_enable[i] <= CTRL0_RESET[CTL0_ENABLE];
					output_invert[i] <= CTRL0_RESET[CTL0_INVERT];
					speed_sel[i] <= CTRL0_RESET[CTL0_SPEED];
					hysteresis_enable[i] <= CTRL0_RESET[CTL0_HYST];
					timer_sync_enable[i] <= CTRL0_RESET[CTL0_SYNC];
				end
				else if (wr_now && address == A0)
				begin
					comp_enable[i] <= wr_byte[CTL0_ENABLE];
					output_invert[i] <= wr_byte[CTL0_INVERT];
					speed_sel[i] <= wr_byte[CTL0_SPEED];
					hysteresis_enable[i] <= wr_byte[CTL0_HYST];
					timer_sync_enable[i] <= wr_byte[CTL0_SYNC];
				end
			end

			// Control register 1 fields
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					rising_edge_irq_enable[i] <= CTRL1_RESET[CTL1_RISE];
					falling_edge_irq_enable[i] <= CTRL1_RESET[CTL1_FALL];
					positive_channel_sel[i] <= CTRL1_RESET[CTL1_PCH_LSB +: 3];
					negative_channel_sel[i] <= CTRL1_RESET[CTL1_NCH_LSB +: 3];
				end
				else if (wr_now && address == A1)
				begin
					rising_edge_irq_enable[i] <= wr_byte[CTL1_RISE];
					falling_edge_irq_enable[i] <= wr_byte[CTL1_FALL];
					positive_channel_sel[i] <= wr_byte[CTL1_PCH_LSB +: 3];
					negative_channel_sel[i] <= wr_byte[CTL1_NCH_LSB +: 3];
				end
			end

			// Core controls follow the register bits
			assign core_power_en[i] = comp_enable[i];
			assign core_hysteresis_en[i] = comp_enable[i] && hysteresis_enable[i];
			assign core_speed_sel[i] = speed_sel[i];

			// Switch decode for both inputs
			comp_input_mux u_mux (
				.clk(clk),
				.resetn(resetn),
				.comp_enable(comp_enable[i]),
				.positive_channel_sel(positive_channel_sel[i]),
				.negative_channel_sel(negative_channel_sel[i]),
				.pos_pin(pos_pin_sw[i]),
				.pos_dac(pos_dac_sw[i]),
				.pos_fvr(pos_fvr_sw[i]),
				.pos_gnd(pos_gnd_sw[i]),
				.neg_pin(neg_pin_sw[i*NEG_PINS +: NEG_PINS]),
				.neg_fvr(neg_fvr_sw[i]),
				.neg_gnd(neg_gnd_sw[i])
			);

			// Raw result brought onto clk
			sync3 u_raw_sync (
				.clk(clk),
				.resetn(resetn),
				.async_in(raw_result[i]),
				.sync_out(raw_sync[i])
			);

			// Polarity applied, latched each cycle; disabled core reads as the polarity bit
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					comp_result_bit[i] <= 1'b0;
				else
					comp_result_bit[i] <= (comp_enable[i] && raw_sync[i]) ^ output_invert[i];
			end

			// Previous value for edge detection
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					prev_result[i] <= 1'b0;
				else
					prev_result[i] <= comp_result_bit[i];
			end

			// Qualified edges on the polarity-adjusted output
			assign edge_hit[i] = (rising_edge_irq_enable[i] && comp_result_bit[i] && !prev_result[i])
				|| (falling_edge_irq_enable[i] && !comp_result_bit[i] && prev_result[i]);
			assign flag_clear[i] = wr_now && address == OFF_IRQ_FLAG && wr_byte[i];

			// Sticky flag, write one to clear, new edge wins
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					comp_irq_flag[i] <= 1'b0;
				else
					comp_irq_flag[i] <= edge_hit[i] || (comp_irq_flag[i] && !flag_clear[i]);
			end

			assign comp_irq_request[i] = comp_irq_flag[i] && comp_irq_enable[i];

			// Unlatched copy straight from the core
			assign async_copy[i] = (comp_enable[i] && raw_result[i]) ^ output_invert[i];

			// Copy resampled on timer clock falling edge
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					sync_copy[i] <= 1'b0;
				else if (tclk_fall && !sync_halt)
					sync_copy[i] <= comp_result_bit[i];
			end

			// External destinations
			assign ext_copy[i] = timer_sync_enable[i] ? sync_copy[i] : async_copy[i];
			assign gate_timer_src[i] = ext_copy[i];
			assign pin_output[i] = ext_copy[i];
		end
	endgenerate

	// Any active source with its shutdown enable stops the generator
	assign waveform_shutdown = |(ext_copy & shutdown_source_enable);

	// Wake on any enabled pending comparator interrupt
	assign wake_request = |comp_irq_request;

	// Port read: pins synchronised, analog pins read zero
	generate
		for (genvar p = 0; p < PORT_W; p++)
		begin : g_pin
			sync3 u_pin_sync (
				.clk(clk),
				.resetn(resetn),
				.async_in(pin_level[p]),
				.sync_out(pin_sync[p])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			port_read_value <= '0;
		else
			port_read_value <= pin_sync & ~analog_pin_select;
	end
endmodule : dual_comparator_control
`default_nettype wire

// ==== testbench/comp_ctrl_props.sv ====
/*
 * Port-level checker for the dual comparator control block.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
`default_nettype none
module comp_ctrl_props
	import comp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	// Comparator side
	input wire logic [comp_pkg::NUM_COMP-1:0] core_power_en,
	input wire logic [comp_pkg::NUM_COMP-1:0] core_hysteresis_en,
	input wire logic [comp_pkg::NUM_COMP-1:0] pos_pin_sw,
	input wire logic [comp_pkg::NUM_COMP-1:0] pos_dac_sw,
	input wire logic [comp_pkg::NUM_COMP-1:0] pos_fvr_sw,
	input wire logic [comp_pkg::NUM_COMP-1:0] pos_gnd_sw,
	input wire logic [comp_pkg::NUM_COMP*comp_pkg::NEG_PINS-1:0] neg_pin_sw,
	input wire logic [comp_pkg::NUM_COMP-1:0] neg_fvr_sw,
	input wire logic [comp_pkg::NUM_COMP-1:0] neg_gnd_sw,
	// Outputs and port
	input wire logic [comp_pkg::NUM_COMP-1:0] gate_timer_src,
	input wire logic [comp_pkg::NUM_COMP-1:0] pin_output,
	input wire logic [comp_pkg::NUM_COMP-1:0] shutdown_source_enable,
	input wire logic waveform_shutdown,
	input wire logic [comp_pkg::NUM_COMP-1:0] comp_irq_request,
	input wire logic wake_request,
	input wire logic [comp_pkg::PORT_W-1:0] pin_level,
	input wire logic [comp_pkg::PORT_W-1:0] analog_pin_select,
	input wire logic [comp_pkg::PORT_W-1:0] port_read_value
);
	// Single domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Switches open once a comparator has been off for two edges
	sw_off_a: assert property ((~core_power_en & ~$past(core_power_en) & (pos_pin_sw | pos_dac_sw | pos_fvr_sw
		| pos_gnd_sw | neg_fvr_sw | neg_gnd_sw | {|neg_pin_sw[7:4], |neg_pin_sw[3:0]})) == 2'b00)
		else $error("switch closed on a disabled comparator");
	pos_onehot_a: assert property ($onehot0({pos_pin_sw[0], pos_dac_sw[0], pos_fvr_sw[0], pos_gnd_sw[0]})
		&& $onehot0({pos_pin_sw[1], pos_dac_sw[1], pos_fvr_sw[1], pos_gnd_sw[1]})) else $error("positive switches clash");
	neg_onehot_a: assert property ($onehot0({neg_pin_sw[3:0], neg_fvr_sw[0], neg_gnd_sw[0]})
		&& $onehot0({neg_pin_sw[7:4], neg_fvr_sw[1], neg_gnd_sw[1]})) else $error("negative switches clash");
	shutdown_follow_a: assert property (waveform_shutdown == |(gate_timer_src & shutdown_source_enable))
		else $error("shutdown does not follow active output");
	ext_copies_a: assert property (gate_timer_src == pin_output) else $error("timer and pin copies differ");
	wake_or_a: assert property (wake_request == |comp_irq_request) else $error("wake request mismatch");
	analog_zero_a: assert property ((port_read_value & $past(analog_pin_select)) == 8'h00)
		else $error("analog pin read back nonzero");
	port_level_a: assert property (($stable(pin_level) && $stable(analog_pin_select))[*5]
		|-> port_read_value == (pin_level & ~analog_pin_select)) else $error("port read value wrong");
	bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");
	read_upper_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	hyst_gate_a: assert property ((core_hysteresis_en & ~core_power_en) == 2'b00)
		else $error("hysteresis on while disabled");
endmodule : comp_ctrl_props

bind dual_comparator_control comp_ctrl_props props_u (.clk, .resetn, .read, .write, .waitrequest, .readdata,
	.core_power_en, .core_hysteresis_en, .pos_pin_sw, .pos_dac_sw, .pos_fvr_sw, .pos_gnd_sw, .neg_pin_sw,
	.neg_fvr_sw, .neg_gnd_sw, .gate_timer_src, .pin_output, .shutdown_source_enable, .waveform_shutdown,
	.comp_irq_request, .wake_request, .pin_level, .analog_pin_select, .port_read_value);
`default_nettype wire

// ==== testbench/comp_far_side.sv ====
/*
 * Behavioural analog comparator cores and gate timer clock source.
 * Assumes input voltages as 8-bit codes per comparator, set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module comp_far_side
	import comp_pkg::*;
(
	// Input voltages
	input wire logic [15:0] vpos,
	input wire logic [15:0] vneg,
	// Timer control
	input wire logic timer_run,
	// Results and clock
	output logic [comp_pkg::NUM_COMP-1:0] raw_result,
	output logic timer_src_clk
);
	// Raw compare, high when positive input is above negative
	always_comb
	begin
		raw_result[0] = vpos[7:0] > vneg[7:0];
		raw_result[1] = vpos[15:8] > vneg[15:8];
	end

	// Timer source, 20 ns period, edges kept off clk edges, stands still when halted
	initial
	begin
		timer_src_clk = 1'b1;
		#1;
		forever
		begin
			#10;
			if (timer_run)
				timer_src_clk = ~timer_src_clk;
		end
	end
endmodule : comp_far_side
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
 * Self-checking bench for the dual comparator control block.
 * Assumes comp_pkg, the design and the far-side model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((ex) !== (got)) begin error_cnt++; $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	import comp_pkg::*;
	logic clk, resetn, read, write, waitrequest, timer_src_clk, timer_src_is_core_clock, sleep_mode;
	logic timer_run, waveform_shutdown, wake_request, e;
	logic [ADDR_W-1:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic [NUM_COMP-1:0] raw_result, core_power_en, core_speed_sel, core_hysteresis_en, gate_timer_src;
	logic [NUM_COMP-1:0] pos_pin_sw, pos_dac_sw, pos_fvr_sw, pos_gnd_sw, neg_fvr_sw, neg_gnd_sw;
	logic [NUM_COMP-1:0] shutdown_source_enable, pin_output, comp_irq_request;
	logic [NUM_COMP*NEG_PINS-1:0] neg_pin_sw;
	logic [PORT_W-1:0] pin_level, analog_pin_select, port_read_value;
	logic [15:0] vpos, vneg;
	logic [7:0] rd, vp, vn;
	int error_cnt, compares, i, inv;

	// Design and far side
	dual_comparator_control dut_u (.clk, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata,
		.waitrequest, .raw_result, .core_power_en, .core_speed_sel, .core_hysteresis_en, .pos_pin_sw, .pos_dac_sw,
		.pos_fvr_sw, .pos_gnd_sw, .neg_pin_sw, .neg_fvr_sw, .neg_gnd_sw, .timer_src_clk, .timer_src_is_core_clock,
		.sleep_mode, .gate_timer_src, .shutdown_source_enable, .waveform_shutdown, .pin_output, .comp_irq_request,
		.wake_request, .pin_level, .analog_pin_select, .port_read_value);
	comp_far_side far_u (.vpos, .vneg, .timer_run, .raw_result, .timer_src_clk);

	// Expected switch sets: {gnd,fvr,dac,pin} and {gnd,fvr,pins}
	function automatic logic [3:0] exp_pos(input logic [2:0] c);
		return (c == POS_PIN) ? 4'h1 : (c == POS_DAC) ? 4'h2 : (c == POS_FVR) ? 4'h4 : (c == POS_GND) ? 4'h8 : 4'h0;
	endfunction : exp_pos
	function automatic logic [5:0] exp_neg(input logic [2:0] c);
		return (c <= NEG_PIN_LAST) ? (6'h01 << c) : (c == NEG_FVR) ? 6'h10 : (c == NEG_GND) ? 6'h20 : 6'h00;
	endfunction : exp_neg
	function automatic logic [ADDR_W-1:0] ctl(input int n, input logic second);
		return (second ? OFF_CTRL1_BASE : OFF_CTRL0_BASE) + (n[0] ? CTRL_STRIDE : 5'h00);
	endfunction : ctl

	// One bus cycle, held until waitrequest is seen low
	task automatic bus_op(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		read <= !is_wr;
		write <= is_wr;
		address <= a;
		writedata <= {24'h000000, d};
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus_op

	task automatic chk_rd(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] ex);
		bus_op(1'b0, a, 8'h00);
		`CHK(nm, ex, rd)
	endtask : chk_rd

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard
	initial
	begin
		#200000;
		error_cnt++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		{resetn, read, write, address, writedata, timer_run, sleep_mode, timer_src_is_core_clock} = '0;
		{shutdown_source_enable, pin_level, analog_pin_select, vpos, vneg} = '0;
		byteenable = 4'h1;
		void'($urandom(32'h1f0e));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		for (int n = 0; n < 2; n++)
		begin
			chk_rd("ctrl0 reset", ctl(n, 0), CTRL0_RESET);
			chk_rd("ctrl1 reset", ctl(n, 1), CTRL1_RESET);
		end
		bus_op(1'b1, 5'h1c, 8'hff);
		chk_rd("unmapped", 5'h1c, 8'h00);
		byteenable <= 4'he;
		bus_op(1'b1, OFF_IRQ_ENABLE, 8'h03);
		byteenable <= 4'h1;
		chk_rd("lane refused", OFF_IRQ_ENABLE, 8'h00);
		chk_rd("mirror reset", OFF_SHARED_RESULT, 8'h00);
		$display("test reset done");
		for (int k = 0; k < 12; k++)
		begin
			i = $urandom % 2;
			inv = $urandom % 2;
			vp = (k == 0) ? 8'h81 : 8'($urandom);
			vn = (k == 0) ? 8'h80 : 8'($urandom);
			if (vp == vn)
				vn = vp ^ 8'h01;
			e = (vp > vn) ^ inv[0];
			// Second pass swaps inputs and flips polarity: same result
			for (int s = 0; s < 2; s++)
			begin
				vpos[i*8 +: 8] <= s ? vn : vp;
				vneg[i*8 +: 8] <= s ? vp : vn;
				shutdown_source_enable <= 2'($urandom);
				bus_op(1'b1, ctl(i, 0), 8'h84 | (8'(inv[0] ^ s[0]) << CTL0_INVERT));
				repeat (8) @(posedge clk);
				bus_op(1'b0, ctl(i, 0), 8'h00);
				`CHK("result bit", e, rd[CTL0_RESULT])
				`CHK("gate copy", e, gate_timer_src[i])
				`CHK("pin copy", e, pin_output[i])
				`CHK("power", 1'b1, core_power_en[i])
				bus_op(1'b0, OFF_SHARED_RESULT, 8'h00);
				`CHK("mirror bit", e, rd[i])
			end
		end
		$display("test polarity done");
		for (int c = 0; c < 8; c++)
			for (int n = 0; n < 2; n++)
			begin
				bus_op(1'b1, ctl(n, 0), 8'h84);
				bus_op(1'b1, ctl(n, 1), 8'((c << 3) | (7 - c)));
				repeat (3) @(posedge clk);
				`CHK("pos switches", exp_pos(3'(c)), {pos_gnd_sw[n], pos_fvr_sw[n], pos_dac_sw[n], pos_pin_sw[n]})
				`CHK("neg switches", exp_neg(3'(7 - c)), {neg_gnd_sw[n], neg_fvr_sw[n], neg_pin_sw[n*4 +: 4]})
				`CHK("hyst clear", 2'b01, {core_hysteresis_en[n], core_speed_sel[n]})
				bus_op(1'b1, ctl(n, 0), 8'h06);
				repeat (3) @(posedge clk);
				`CHK("off pos", 4'h0, {pos_gnd_sw[n], pos_fvr_sw[n], pos_dac_sw[n], pos_pin_sw[n]})
				`CHK("off neg", 6'h00, {neg_gnd_sw[n], neg_fvr_sw[n], neg_pin_sw[n*4 +: 4]})
				`CHK("hyst off", 1'b0, core_hysteresis_en[n])
				bus_op(1'b1, ctl(n, 0), 8'h86);
				repeat (2) @(posedge clk);
				`CHK("hyst on", 1'b1, core_hysteresis_en[n])
			end
		$display("test channels done");
		bus_op(1'b1, ctl(1, 0), 8'h04);
		bus_op(1'b1, ctl(1, 1), 8'h80);
		bus_op(1'b1, OFF_IRQ_FLAG, 8'h03);
		bus_op(1'b1, OFF_IRQ_ENABLE, 8'h02);
		bus_op(1'b1, ctl(1, 0), 8'h14);
		repeat (4) @(posedge clk);
		`CHK("irq request", 2'b10, comp_irq_request)
		`CHK("wake", 1'b1, wake_request)
		bus_op(1'b1, OFF_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge clk);
		`CHK("masked request", 2'b00, comp_irq_request)
		chk_rd("flag sticky", OFF_IRQ_FLAG, 8'h02);
		bus_op(1'b1, OFF_IRQ_FLAG, 8'h02);
		chk_rd("flag cleared", OFF_IRQ_FLAG, 8'h00);
		bus_op(1'b1, ctl(1, 0), 8'h04);
		repeat (4) @(posedge clk);
		chk_rd("falling refused", OFF_IRQ_FLAG, 8'h00);
		bus_op(1'b1, ctl(1, 1), 8'h40);
		bus_op(1'b1, ctl(1, 0), 8'h14);
		repeat (4) @(posedge clk);
		chk_rd("rising refused", OFF_IRQ_FLAG, 8'h00);
		bus_op(1'b1, ctl(1, 0), 8'h04);
		repeat (4) @(posedge clk);
		chk_rd("falling flag", OFF_IRQ_FLAG, 8'h02);
		bus_op(1'b1, OFF_IRQ_FLAG, 8'h02);
		bus_op(1'b1, ctl(1, 1), 8'h80);
		vpos[15:8] <= 8'hf0;
		vneg[15:8] <= 8'h10;
		repeat (8) @(posedge clk);
		bus_op(1'b1, ctl(1, 0), 8'h84);
		repeat (4) @(posedge clk);
		chk_rd("enable edge flag", OFF_IRQ_FLAG, 8'h02);
		$display("test interrupt done");
		timer_run <= 1'b1;
		vpos[7:0] <= 8'h10;
		vneg[7:0] <= 8'h20;
		bus_op(1'b1, ctl(0, 0), 8'h85);
		repeat (30) @(posedge clk);
		`CHK("sync low", 1'b0, gate_timer_src[0])
		timer_run <= 1'b0;
		vpos[7:0] <= 8'h30;
		repeat (30) @(posedge clk);
		`CHK("sync held", 1'b0, gate_timer_src[0])
		chk_rd("internal latch", ctl(0, 0), 8'hc5);
		timer_run <= 1'b1;
		repeat (30) @(posedge clk);
		`CHK("sync high", 1'b1, gate_timer_src[0])
		sleep_mode <= 1'b1;
		timer_src_is_core_clock <= 1'b1;
		vpos[7:0] <= 8'h00;
		repeat (30) @(posedge clk);
		`CHK("sleep hold", 1'b1, gate_timer_src[0])
		sleep_mode <= 1'b0;
		repeat (30) @(posedge clk);
		`CHK("wake update", 1'b0, gate_timer_src[0])
		$display("test sync done");
		for (int k = 0; k < 6; k++)
		begin
			pin_level <= 8'($urandom);
			analog_pin_select <= (k == 0) ? 8'hff : 8'($urandom);
			repeat (8) @(posedge clk);
			`CHK("port read", pin_level & ~analog_pin_select, port_read_value)
		end
		$display("test port done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
